// ===== core/oms_pkg.sv
/*
  Package for the operating mode sequencer: register offsets, field
  positions, reset values, mode codes, states and the sample tick divider.
  Assumes a 100 MHz core clock and 7-bit register addresses.
*/
package oms_pkg;
  // Register offsets
  localparam logic [6:0] OMS_ADDR_STATUS = 7'h00;
  localparam logic [6:0] OMS_ADDR_MODE = 7'h10;
  localparam logic [6:0] OMS_ADDR_LED1 = 7'h22;
  localparam logic [6:0] OMS_ADDR_LED2 = 7'h23;
  localparam logic [6:0] OMS_ADDR_LED3 = 7'h24;
  localparam logic [6:0] OMS_ADDR_CLKCTL = 7'h4b;
  // Field positions and values
  localparam int OMS_CLK_EN_BIT = 7;
  localparam int OMS_FIFO_CLR_BIT = 15;
  localparam int OMS_SLEW_LO = 4;
  localparam int OMS_SLEW_HI = 6;
  localparam int OMS_INT_W = 8;
  localparam logic [15:0] OMS_REG_RESET = 16'h0000;
  localparam logic [1:0] OMS_MODE_STANDBY = 2'h0;
  localparam logic [1:0] OMS_MODE_PROGRAM = 2'h1;
  localparam logic [1:0] OMS_MODE_NORMAL = 2'h2;
  // Sample clock timing
  localparam int OMS_CLK_HZ = 100_000_000;
  localparam int OMS_SAMPLE_HZ = 32_000;
  localparam int OMS_TICK_DIV = OMS_CLK_HZ / OMS_SAMPLE_HZ;
  localparam logic [11:0] OMS_TICK_LAST = 12'(OMS_TICK_DIV - 1);
  localparam logic [11:0] OMS_TICK_ZERO = 12'h000;

  typedef enum {OMS_ST_STANDBY, OMS_ST_PROGRAM, OMS_ST_NORMAL, OMS_ST_HANG} oms_state_t;

  // Slew-rate selections of the three LED current sinks
  typedef struct packed {
    logic [2:0] led3;
    logic [2:0] led2;
    logic [2:0] led1;
  } oms_slew_t;
endpackage

// ===== core/oms_sequencer.sv
/*
  Operating mode sequencer: mode register, sample clock enable, status
  clear writes and LED slew configuration, with the mode state machine.
  Assumes the register port is driven by logic on CLK (one strobe a cycle).
*/
// Notes on behaviour
// R01: Resets into standby, mode register reads zero.
// R02: Clock enable bit starts 32 kHz sample tick.
// R03: No mode change while sample clock stopped.
// R04: Mode one requests program, needs clock too.
// R05: Host configures registers while in program mode.
// R06: Mode two starts normal sampling.
// R07: Host stops via program, then standby.
// R08: Status write clears interrupts, 0x80FF empties FIFO.
// R09: Clock disabled outside standby locks machine until reset.
// R10: Host clears clock enable only in standby.
// R11: Each LED driver has slew field bits 6:4.
// R12: Status bit 15 write empties the FIFO.
// R13: Mode values above two are ignored.
`timescale 1ns/1ps
`default_nettype none
module oms_sequencer (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [6:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] INT_EVENTS,
  output logic [15:0] REG_RDATA,
  output logic [1:0] MODE,
  output logic SAMPLING,
  output logic HUNG,
  output logic SAMPLE_TICK,
  output logic FIFO_CLEAR,
  output oms_pkg::oms_slew_t LED_SLEW
);
  import oms_pkg::*;

  oms_state_t state_r, state_nxt;
  logic [1:0] req_r;
  logic [15:0] clkctl_r;
  logic [15:0] led_r [3];
  logic [7:0] int_r;
  logic [11:0] cnt_r;
  logic [1:0] mode_nxt;

  // Address decode
  wire wr_status = REG_WR && (REG_ADDR == OMS_ADDR_STATUS);
  wire wr_mode = REG_WR && (REG_ADDR == OMS_ADDR_MODE);
  wire wr_clkctl = REG_WR && (REG_ADDR == OMS_ADDR_CLKCTL);
  wire clk_en = clkctl_r[OMS_CLK_EN_BIT];
  wire tick_now = clk_en && (cnt_r == OMS_TICK_LAST);
  // Mode values above normal do not count as requests
  wire mode_ok = (REG_WDATA <= 16'(OMS_MODE_NORMAL));
  // The hazard: clearing the enable outside standby strands the machine
  wire hang_hit = wr_clkctl && !REG_WDATA[OMS_CLK_EN_BIT] &&
                  (state_r == OMS_ST_PROGRAM || state_r == OMS_ST_NORMAL);
  // R03: stale tick dropped
  // A tick already in flight when the enable drops must not move the machine
  wire step_ok = SAMPLE_TICK && clk_en;

  // Next state of the mode machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OMS_ST_HANG: state_nxt = OMS_ST_HANG;
      default: begin
        if (hang_hit) begin
          // R09: locked until reset
          state_nxt = OMS_ST_HANG;
        end else if (step_ok) begin
          // R04: move only on a sample tick
          case (req_r)
            OMS_MODE_PROGRAM: state_nxt = OMS_ST_PROGRAM;
            OMS_MODE_NORMAL: state_nxt = OMS_ST_NORMAL;
            default: state_nxt = OMS_ST_STANDBY;
          endcase
        end
      end
    endcase
  end

  // Applied mode code; a hung machine keeps showing the old code
  always_comb begin
    case (state_nxt)
      OMS_ST_PROGRAM: mode_nxt = OMS_MODE_PROGRAM;
      OMS_ST_NORMAL: mode_nxt = OMS_MODE_NORMAL;
      OMS_ST_HANG: mode_nxt = MODE;
      default: mode_nxt = OMS_MODE_STANDBY;
    endcase
  end

  // R01: state and mode start in standby
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= OMS_ST_STANDBY;
      MODE <= OMS_MODE_STANDBY;
      SAMPLING <= 1'b0;
      HUNG <= 1'b0;
    end else begin
      state_r <= state_nxt;
      MODE <= mode_nxt;
      // R06: sampling runs in normal mode
      SAMPLING <= (state_nxt == OMS_ST_NORMAL);
      HUNG <= (state_nxt == OMS_ST_HANG);
    end
  end

  // Mode request register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      req_r <= OMS_MODE_STANDBY;
    end else if (wr_mode && mode_ok) begin
      // R13: bad codes dropped
      req_r <= REG_WDATA[1:0];
    end
  end

  // R02: sample tick divider runs only while enabled
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= OMS_TICK_ZERO;
      SAMPLE_TICK <= 1'b0;
    end else begin
      // R03: no new ticks while stopped; a tick already registered still shows for one cycle
      cnt_r <= (!clk_en || tick_now) ? OMS_TICK_ZERO : cnt_r + 12'h001;
      SAMPLE_TICK <= tick_now;
    end
  end

  // Clock control register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      clkctl_r <= OMS_REG_RESET;
    end else if (wr_clkctl) begin
      clkctl_r <= REG_WDATA;
    end
  end

  // R11: three LED configuration registers
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_led
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          led_r[gi] <= OMS_REG_RESET;
        end else if (REG_WR && REG_ADDR == OMS_ADDR_LED1 + 7'(gi)) begin
          led_r[gi] <= REG_WDATA;
        end
      end
    end
  endgenerate

  // Slew selections leave straight from flops
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LED_SLEW <= '0;
    end else begin
      LED_SLEW.led1 <= led_r[0][OMS_SLEW_HI:OMS_SLEW_LO];
      LED_SLEW.led2 <= led_r[1][OMS_SLEW_HI:OMS_SLEW_LO];
      LED_SLEW.led3 <= led_r[2][OMS_SLEW_HI:OMS_SLEW_LO];
    end
  end

  // R08: write-one clears flags; a new event wins over the clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      int_r <= 8'h00;
      FIFO_CLEAR <= 1'b0;
    end else begin
      int_r <= (int_r & ~(wr_status ? REG_WDATA[OMS_INT_W-1:0] : 8'h00)) | INT_EVENTS;
      // R12: one-cycle FIFO empty pulse
      FIFO_CLEAR <= wr_status && REG_WDATA[OMS_FIFO_CLR_BIT];
    end
  end

  // Read mux; unmapped addresses read zero
  wire [15:0] rd_mux =
    (REG_ADDR == OMS_ADDR_STATUS) ? {8'h00, int_r} :
    (REG_ADDR == OMS_ADDR_MODE) ? {14'h0, MODE} :
    (REG_ADDR == OMS_ADDR_LED1) ? led_r[0] :
    (REG_ADDR == OMS_ADDR_LED2) ? led_r[1] :
    (REG_ADDR == OMS_ADDR_LED3) ? led_r[2] :
    (REG_ADDR == OMS_ADDR_CLKCTL) ? clkctl_r : 16'h0000;

  // Read data held until the next read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= OMS_REG_RESET;
    end else if (REG_RD) begin
      REG_RDATA <= rd_mux;
    end
  end

  // Checks on the mode machine and register effects
  a_hang_stays: assert property (@(posedge CLK) disable iff (RST) // R09
    HUNG |=> HUNG && $stable(MODE)) else $error("hang state left");
  a_hang_entry: assert property (@(posedge CLK) disable iff (RST) // R09
    hang_hit |=> HUNG) else $error("clock clear outside standby not hung");
  a_clk_off_still: assert property (@(posedge CLK) disable iff (RST) // R03
    !clk_en && !hang_hit |=> $stable(state_r)) else $error("moved with clock off");
  a_prog_tick: assert property (@(posedge CLK) disable iff (RST) // R04
    step_ok && req_r == OMS_MODE_PROGRAM && !HUNG && !hang_hit |=>
      MODE == OMS_MODE_PROGRAM) else $error("program request not applied");
  a_normal_sample: assert property (@(posedge CLK) disable iff (RST) // R06
    step_ok && req_r == OMS_MODE_NORMAL && !HUNG && !hang_hit |=>
      SAMPLING && MODE == OMS_MODE_NORMAL)
    else $error("normal request without sampling");
  a_tick_spacing: assert property (@(posedge CLK) disable iff (RST) // R02
    SAMPLE_TICK |=> !SAMPLE_TICK [*8]) else $error("ticks too close");
  a_bad_mode: assert property (@(posedge CLK) disable iff (RST) // R13
    wr_mode && !mode_ok |=> $stable(req_r)) else $error("bad mode code taken");
  a_fifo_clear: assert property (@(posedge CLK) disable iff (RST) // R12
    wr_status && REG_WDATA[OMS_FIFO_CLR_BIT] |=> FIFO_CLEAR ##1 !FIFO_CLEAR)
    else $error("FIFO clear pulse wrong");
  a_int_clear: assert property (@(posedge CLK) disable iff (RST) // R08
    wr_status && REG_WDATA[7:0] == 8'hff && INT_EVENTS == 8'h00 |=> int_r == 8'h00)
    else $error("interrupt flags not cleared");
  a_slew_field: assert property (@(posedge CLK) disable iff (RST) // R11
    REG_WR && REG_ADDR == OMS_ADDR_LED1 |=> ##1 LED_SLEW.led1 == $past(REG_WDATA[6:4], 2))
    else $error("slew field not applied");
endmodule // oms_sequencer
`default_nettype wire

// ===== verification/oms_host.sv
/*
  Host model for the sequencer register port: one access task with
  one-cycle strobes. Assumes CLK comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module oms_host (
  input wire logic CLK,
  input wire logic [15:0] REG_RDATA,
  output var logic [6:0] REG_ADDR,
  output var logic [15:0] REG_WDATA,
  output var logic REG_WR,
  output var logic REG_RD
);
  // Idle port at time zero
  initial begin
    REG_ADDR = 7'h00;
    REG_WDATA = 16'h0000;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end
  // Address and data are inverted on release so a stale value never passes as valid
  task automatic acc(input logic [6:0] a, input logic [15:0] d, input logic w,
                     output logic [15:0] q);
    @(posedge CLK);
    #1;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = w;
    REG_RD = !w;
    @(posedge CLK);
    #1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = ~a;
    REG_WDATA = ~d;
    @(posedge CLK);
    #1;
    q = REG_RDATA; // Read data holds until the next read
  endtask
endmodule // oms_host
`default_nettype wire

// ===== verification/oms_sequencer_tb.sv
/*
  Self-checking bench for the operating mode sequencer.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module oms_sequencer_tb;
  import oms_pkg::*;
  logic CLK, RST, REG_WR, REG_RD, SAMPLING, HUNG, SAMPLE_TICK, FIFO_CLEAR;
  logic [6:0] REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA, q;
  logic [7:0] INT_EVENTS;
  logic [1:0] MODE;
  oms_slew_t LED_SLEW;
  int checks = 0, error_cnt = 0, fifo_seen = 0, tick_n = 0;
  oms_sequencer oms_sequencer_inst (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .INT_EVENTS(INT_EVENTS),
    .REG_RDATA(REG_RDATA), .MODE(MODE), .SAMPLING(SAMPLING), .HUNG(HUNG),
    .SAMPLE_TICK(SAMPLE_TICK), .FIFO_CLEAR(FIFO_CLEAR), .LED_SLEW(LED_SLEW));
  oms_host oms_host_inst (.CLK(CLK), .REG_RDATA(REG_RDATA), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD));
  // Clock generation
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Count one-cycle FIFO clear pulses
  always @(posedge CLK) begin
    if (FIFO_CLEAR === 1'b1) fifo_seen++;
  end
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    oms_host_inst.acc(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    oms_host_inst.acc(a, 16'h0000, 1'b0, q);
    `CHK(q, e)
  endtask
  // Bounded wait for a sample tick, then let the mode update land
  task automatic tick();
    int n;
    n = 0;
    while (SAMPLE_TICK !== 1'b1 && n < 4000) begin
      @(posedge CLK);
      #1;
      n++;
    end
    tick_n = n;
    if (n == 4000) begin
      error_cnt++;
      finish_test();
    end
    repeat (2) @(posedge CLK);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    RST = 1'b1;
    INT_EVENTS = 8'h00;
    repeat (10) @(posedge CLK);
    #1;
    RST = 1'b0;
    rd(OMS_ADDR_MODE, 16'h0000);
    rd(7'h7f, 16'h0000);
    wr(OMS_ADDR_MODE, 16'h0001);
    repeat (3200) @(posedge CLK);
    `CHK(MODE, OMS_MODE_STANDBY)
    wr(OMS_ADDR_CLKCTL, 16'h0080);
    tick();
    `CHK(tick_n, OMS_TICK_DIV - 1)
    `CHK(MODE, OMS_MODE_PROGRAM)
    $display("test start done");
    // configure slew while in program mode
    wr(OMS_ADDR_LED1, 16'h0010);
    wr(OMS_ADDR_LED2, 16'h0020);
    wr(OMS_ADDR_LED3, 16'h0070);
    `CHK(LED_SLEW, 9'h1d1)
    rd(OMS_ADDR_LED1, 16'h0010);
    wr(OMS_ADDR_MODE, 16'h0002);
    tick();
    `CHK({MODE, SAMPLING}, {OMS_MODE_NORMAL, 1'b1})
    wr(OMS_ADDR_MODE, 16'h0003);
    tick();
    rd(OMS_ADDR_MODE, 16'h0002);
    $display("test normal done");
    // leave via program mode, clear flags, then standby
    wr(OMS_ADDR_MODE, 16'h0001);
    tick();
    INT_EVENTS = 8'ha5;
    @(posedge CLK);
    #1;
    INT_EVENTS = 8'h00;
    rd(OMS_ADDR_STATUS, 16'h00a5);
    wr(OMS_ADDR_STATUS, 16'h00ff);
    rd(OMS_ADDR_STATUS, 16'h0000);
    `CHK(fifo_seen, 0)
    wr(OMS_ADDR_STATUS, 16'h80ff);
    `CHK(fifo_seen, 1)
    wr(OMS_ADDR_MODE, 16'h0000);
    tick();
    `CHK(MODE, OMS_MODE_STANDBY)
    // clock stop is legal in standby
    wr(OMS_ADDR_CLKCTL, 16'h0000);
    `CHK(HUNG, 1'b0)
    $display("test stop done");
    wr(OMS_ADDR_CLKCTL, 16'h0080);
    wr(OMS_ADDR_MODE, 16'h0001);
    tick();
    wr(OMS_ADDR_CLKCTL, 16'h0000);
    wr(OMS_ADDR_MODE, 16'h0000);
    wr(OMS_ADDR_CLKCTL, 16'h0080);
    tick();
    `CHK({HUNG, MODE}, {1'b1, OMS_MODE_PROGRAM})
    $display("test hang done");
    // a mid-run reset lifts the lock and returns to standby
    RST = 1'b1;
    @(posedge CLK);
    #1;
    RST = 1'b0;
    `CHK({HUNG, MODE, SAMPLING}, 4'h0)
    rd(OMS_ADDR_CLKCTL, 16'h0000);
    rd(OMS_ADDR_MODE, 16'h0000);
    $display("test reset done");
    finish_test();
  end
endmodule // oms_sequencer_tb
`default_nettype wire
